// *** pfwp_top.v ***
// program flash write protection: config load, shadow check and access decision
//
// Function
// - with the code guard active, external reads and writes of program memory are refused.
// - with the write guard at 0, every internal write and erase is blocked.
// - a write or erase inside the protected segment drops the memory interlock.
// - segment protection only adds to global protection.
// - segment bounds act only while the segment disable is 0.
// - the six-bit page field picks one 512-word page which is itself protected.
// - with end select 0 the range runs from address zero through the chosen page.
// - with end select 1 the range runs from the chosen page to the end of memory.
// - with the last page guard at 0 the final page is always write protected.
// - with segment disable and last page guard both 1 only global guards apply.
// - each configuration register has a complement shadow compared continuously.
// - a configuration bit that changes unexpectedly flags a parity error and resets.
// - the configuration is loaded from the configuration words in flash.
// - the code guard also shields the configuration words from external access.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pfwp_regs.vh"

module pfwp_top (
	input  wire                    mclk_i,
	input  wire                    rst_i,
	// apb slave
	input  wire                    psel_i,
	input  wire                    penable_i,
	input  wire                    pwrite_i,
	input  wire [11:0]             paddr_i,
	input  wire [31:0]             pwdata_i,
	output reg  [31:0]             prdata_o,
	output reg                     pready_o,
	output reg                     pslverr_o,
	// configuration word load from flash
	input  wire                    cfg_load_i,
	input  wire [15:0]             cfg_word_i,
	input  wire [`PFWP_CFG_WIDTH-1:0] cfg_upset_i,
	// memory controller request
	input  wire                    req_valid_i,
	input  wire                    req_ext_i,
	input  wire                    req_write_i,
	input  wire [`PFWP_ADDR_W-1:0] req_addr_i,
	output reg                     grant_o,
	output reg                     nonvolatile_memory_interlock_o,
	output reg                     refuse_o,
	// device reset request and parity flag
	output reg                     dev_reset_o,
	output reg                     parity_err_o
);

	// ==========================================================================
	// configuration register with shadow
	wire [`PFWP_CFG_WIDTH-1:0] cfg_val;
	wire                       cfg_mismatch;

	// config data comes only from the stored flash word
	pfwp_shadow_cmp #(
		.W   (`PFWP_CFG_WIDTH),
		.RST (`PFWP_CFG_RESET)
	) u_cfg (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.load_i     (cfg_load_i),
		.data_i     (cfg_word_i[`PFWP_CFG_WIDTH-1:0]),
		.upset_i    (cfg_upset_i),
		.value_o    (cfg_val),
		.mismatch_o (cfg_mismatch)
	);

	wire [5:0] boundary_page_select   = cfg_val[`PFWP_CFG_PAGE_MSB:`PFWP_CFG_PAGE_LSB];
	wire       segment_end_select     = cfg_val[`PFWP_CFG_END_BIT];
	wire       last_page_guard        = cfg_val[`PFWP_CFG_LASTPG_BIT];
	wire       segment_guard_disable  = cfg_val[`PFWP_CFG_SEGDIS_BIT];
	wire       global_write_guard     = cfg_val[`PFWP_CFG_WGUARD_BIT];
	wire       global_code_guard_n    = cfg_val[`PFWP_CFG_CGUARD_BIT];

	// ==========================================================================
	// segment range decode
	wire [`PFWP_ADDR_W-1:0] page_lo;
	wire [`PFWP_ADDR_W-1:0] page_hi;
	wire [`PFWP_ADDR_W-1:0] last_pg_lo;

	// the last page starts at the last address with the in-page offset cleared
	localparam [`PFWP_ADDR_W-1:0] LAST_ADDR = `PFWP_LAST_ADDR;

	// the chosen page is inclusive at both ends
	assign page_lo    = {{(`PFWP_ADDR_W-15){1'b0}}, boundary_page_select, 9'h000};
	assign page_hi    = {{(`PFWP_ADDR_W-15){1'b0}}, boundary_page_select, 9'h1FF};
	assign last_pg_lo = {LAST_ADDR[`PFWP_ADDR_W-1:`PFWP_PAGE_SHIFT], {`PFWP_PAGE_SHIFT{1'b0}}};

	wire in_low_seg  = (req_addr_i <= page_hi);
	wire in_high_seg = (req_addr_i >= page_lo);
	wire in_last_pg  = (req_addr_i >= last_pg_lo);
	wire is_cfg_word = (req_addr_i >= `PFWP_CFGWORD_ADDR);

	// segment bounds only count while disable is 0
	wire seg_hit  = !segment_guard_disable &&
		(segment_end_select ? in_high_seg : in_low_seg);
	// last page guard acts regardless of other settings
	wire last_hit = !last_page_guard && in_last_pg;
	wire seg_prot = seg_hit || last_hit;

	// ==========================================================================
	// combinational access decision
	reg allow_c;
	reg interlock_c;
	reg refuse_c;

	always @* begin
		allow_c     = 1'b1;
		interlock_c = 1'b1;
		refuse_c    = 1'b0;
		if (req_ext_i) begin
			// external programmer: code guard refuses reads and writes
			if (!global_code_guard_n)
				refuse_c = 1'b1;
			if (req_write_i && (seg_prot || !global_write_guard))
				refuse_c = 1'b1;
		end else if (req_write_i) begin
			// internal self-write: either guard set blocks it
			if (!global_write_guard || seg_prot)
				refuse_c = 1'b1;
		end
		if (is_cfg_word && !global_code_guard_n && req_ext_i)
			refuse_c = 1'b1;
		if (refuse_c) begin
			allow_c     = 1'b0;
			interlock_c = 1'b0;
		end
	end

	// outputs from flops; grant drops so memory stays unchanged
	always @(posedge mclk_i) begin
		if (rst_i) begin
			grant_o                        <= 1'b0;
			nonvolatile_memory_interlock_o <= 1'b0;
			refuse_o                       <= 1'b0;
		end else begin
			grant_o                        <= req_valid_i && allow_c;
			nonvolatile_memory_interlock_o <= req_valid_i && req_write_i && interlock_c;
			refuse_o                       <= req_valid_i && refuse_c;
		end
	end

	// ==========================================================================
	// parity error and forced reset
	reg [3:0] rst_cnt_reg;
	// pulse length in cycles, cut to the counter width on purpose
	localparam [31:0] RST_LOAD = `PFWP_RST_CYC;
	reg [7:0] fault_cnt_reg;
	reg [`PFWP_ADDR_W-1:0] last_refused_reg;

	// a shadow mismatch asserts a reset pulse of fixed width
	always @(posedge mclk_i) begin
		if (rst_i) begin
			rst_cnt_reg  <= 4'h0;
			dev_reset_o  <= 1'b0;
			parity_err_o <= 1'b0;
		end else begin
			if (cfg_mismatch)
				parity_err_o <= 1'b1;
			if (cfg_mismatch && rst_cnt_reg == 4'h0) begin
				rst_cnt_reg <= RST_LOAD[3:0];
				dev_reset_o <= 1'b1;
			end else if (rst_cnt_reg != 4'h0) begin
				rst_cnt_reg <= rst_cnt_reg - 4'h1;
				dev_reset_o <= (rst_cnt_reg != 4'h1);
			end
		end
	end

	// refusal counter and last refused address for software
	always @(posedge mclk_i) begin
		if (rst_i) begin
			fault_cnt_reg    <= 8'h00;
			last_refused_reg <= {`PFWP_ADDR_W{1'b0}};
		end else if (req_valid_i && refuse_c) begin
			if (fault_cnt_reg != 8'hFF)
				fault_cnt_reg <= fault_cnt_reg + 8'h01;
			last_refused_reg <= req_addr_i;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == `PFWP_OFS_FAULT) begin
			fault_cnt_reg <= 8'h00;
		end
	end

	// ==========================================================================
	// apb slave: one wait-free access phase, unmapped gives pslverr
	always @(posedge mclk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else if (psel_i && !penable_i) begin
			pready_o  <= 1'b1;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
			if (paddr_i == `PFWP_OFS_CFG)
				prdata_o <= {21'h000000, cfg_val};
			else if (paddr_i == `PFWP_OFS_STATUS)
				prdata_o <= {29'h00000000, dev_reset_o, parity_err_o, cfg_mismatch};
			else if (paddr_i == `PFWP_OFS_FAULT)
				prdata_o <= {24'h000000, fault_cnt_reg};
			else if (paddr_i == `PFWP_OFS_LOADADR)
				prdata_o <= {15'h0000, last_refused_reg};
			else
				pslverr_o <= 1'b1;
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule

// *** pfwp_regs.vh ***
// register offsets, field positions, reset values and sizes of the flash write guard
`ifndef PFWP_REGS_VH
`define PFWP_REGS_VH

// ==========================================================================
// apb register map (byte addresses)
`define PFWP_OFS_CFG      12'h000
`define PFWP_OFS_STATUS   12'h004
`define PFWP_OFS_FAULT    12'h008
`define PFWP_OFS_LOADADR  12'h00C

// ==========================================================================
// config word fields (low eleven bits of the configuration word)
`define PFWP_CFG_PAGE_LSB     0
`define PFWP_CFG_PAGE_MSB     5
`define PFWP_CFG_END_BIT      6
`define PFWP_CFG_LASTPG_BIT   7
`define PFWP_CFG_SEGDIS_BIT   8
`define PFWP_CFG_WGUARD_BIT   9
`define PFWP_CFG_CGUARD_BIT   10
`define PFWP_CFG_WIDTH        11

// erased flash reads all ones, so the unprogrammed settings are the reset value
`define PFWP_CFG_RESET        11'h7FF

// ==========================================================================
// program memory geometry in word addresses
`define PFWP_ADDR_W           17
`define PFWP_PAGE_SHIFT       9
`define PFWP_LAST_ADDR        17'h0ABFF
`define PFWP_CFGWORD_ADDR     17'h0ABFE

// ==========================================================================
// timing: reset pulse width after a parity error
`define PFWP_RST_NS           50
`define PFWP_CLK_NS           5
`define PFWP_RST_CYC          ((`PFWP_RST_NS + `PFWP_CLK_NS - 1) / `PFWP_CLK_NS)

`endif

// *** pfwp_shadow_cmp.v ***
// one configuration register with its complement shadow and a mismatch check
`timescale 1ns/1ps

module pfwp_shadow_cmp #(
	parameter W = 11,
	parameter [W-1:0] RST = {W{1'b1}}
) (
	input  wire         mclk_i,
	input  wire         rst_i,
	input  wire         load_i,
	input  wire [W-1:0] data_i,
	input  wire [W-1:0] upset_i,
	output wire [W-1:0] value_o,
	output reg          mismatch_o
);

	reg [W-1:0] value_reg;
	reg [W-1:0] shadow_reg;

	// the upset input models a cell disturbance on the live copy only
	always @(posedge mclk_i) begin
		if (rst_i) begin
			value_reg  <= RST;
			shadow_reg <= ~RST;
		end else if (load_i) begin
			value_reg  <= data_i;
			shadow_reg <= ~data_i;
		end else begin
			value_reg  <= value_reg ^ upset_i;
		end
	end

	// compare every cycle, registered so the flag is glitch free
	always @(posedge mclk_i) begin
		if (rst_i)
			mismatch_o <= 1'b0;
		else
			mismatch_o <= (value_reg != ~shadow_reg);
	end

	assign value_o = value_reg;

endmodule

// *** pfwp_sva.sv ***
// assertion checker on the ports of the flash write guard
`timescale 1ns/1ps
module pfwp_sva (
	input wire        mclk_i,
	input wire        rst_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pready_o,
	input wire        cfg_load_i,
	input wire [15:0] cfg_word_i,
	input wire [10:0] cfg_upset_i,
	input wire        req_valid_i,
	input wire        req_ext_i,
	input wire        req_write_i,
	input wire [16:0] req_addr_i,
	input wire        grant_o,
	input wire        nonvolatile_memory_interlock_o,
	input wire        refuse_o,
	input wire        dev_reset_o,
	input wire        parity_err_o
);
	reg  [10:0] c_reg;
	wire [16:0] base = {2'h0, c_reg[5:0], 9'h000};
	wire        seg  = !c_reg[8] && (c_reg[6] ? req_addr_i >= base : req_addr_i <= base + 17'h1FF);
	wire        last = !c_reg[7] && req_addr_i >= 17'h0AA00;
	wire        ok   = !(req_ext_i && !c_reg[10]) && !(req_write_i && (!c_reg[9] || seg || last));
	// requests under fault injection are left out, the live copy is then unknown
	wire        go   = req_valid_i && cfg_upset_i == 11'h000;
	// ======================================================================
	// mirror of the loaded settings, erased flash after reset
	always @(posedge mclk_i)
		if (rst_i) c_reg <= 11'h7FF;
		else if (cfg_load_i) c_reg <= cfg_word_i[10:0];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_grant; go |=> grant_o == $past(ok); endproperty
	a_grant: assert property (p_grant) else $error("grant wrong");
	property p_refuse; go |=> refuse_o != grant_o; endproperty
	a_refuse: assert property (p_refuse) else $error("refuse wrong");
	property p_ilk; go && req_write_i |=> nonvolatile_memory_interlock_o == grant_o; endproperty
	a_ilk: assert property (p_ilk) else $error("interlock wrong");
	property p_cg; go && req_ext_i && !c_reg[10] |=> refuse_o; endproperty
	a_cg: assert property (p_cg) else $error("code guard");
	property p_wg; go && req_write_i && !c_reg[9] |=> !nonvolatile_memory_interlock_o; endproperty
	a_wg: assert property (p_wg) else $error("write guard");
	property p_last; go && req_write_i && last |=> refuse_o; endproperty
	a_last: assert property (p_last) else $error("last page");
	property p_run; go && !req_ext_i && !req_write_i |=> grant_o; endproperty
	a_run: assert property (p_run) else $error("internal read");
	property p_par; cfg_upset_i != 11'h000 |-> ##3 parity_err_o && dev_reset_o; endproperty
	a_par: assert property (p_par) else $error("parity");
	// cycles that the reset request has stood high so far, saturating
	reg [4:0] hi_cnt;
	always @(posedge mclk_i)
		if (rst_i) hi_cnt <= 5'h00;
		else if (!dev_reset_o) hi_cnt <= 5'h00;
		else if (hi_cnt != 5'h1F) hi_cnt <= hi_cnt + 5'h01;
	property p_rlen; $fell(dev_reset_o) |-> hi_cnt == 5'h0A; endproperty
	a_rlen: assert property (p_rlen) else $error("reset width");
	property p_rmax; dev_reset_o |-> hi_cnt < 5'h0A; endproperty
	a_rmax: assert property (p_rmax) else $error("reset too long");
	property p_apb; psel_i && !penable_i |=> pready_o; endproperty
	a_apb: assert property (p_apb) else $error("apb ready");
endmodule

// *** pfwp_nvm_model.sv ***
// flash array stand-in: commits a write only while the interlock is open
`timescale 1ns/1ps
module pfwp_nvm_model (
	input  wire        mclk_i,
	input  wire        rst_i,
	input  wire        wr_i,
	input  wire        unlock_i,
	output reg  [15:0] hits_o
);
	reg wr_reg;
	// the interlock answers a cycle late, so the write intent is held one cycle
	always @(posedge mclk_i) begin
		wr_reg <= wr_i;
		if (rst_i) hits_o <= 16'h0000;
		else if (wr_reg && unlock_i) hits_o <= hits_o + 16'h0001;
	end
endmodule

// *** pfwp_top_tb.sv ***
// self-checking bench for the flash write guard
`timescale 1ns/1ps
module pfwp_top_tb;
	reg mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	reg [11:0] paddr_i = 0;
	reg [31:0] pwdata_i = 0, rd;
	reg cfg_load_i = 0, req_valid_i = 0, req_ext_i = 0, req_write_i = 0, err;
	reg [15:0] cfg_word_i = 0;
	reg [10:0] cfg_upset_i = 0, cfg;
	reg [16:0] req_addr_i = 0, a, lr = 0;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, grant_o, nonvolatile_memory_interlock_o, refuse_o;
	wire dev_reset_o, parity_err_o;
	wire [15:0] hits;
	integer fails = 0, checks = 0, cyc = 0, nwr = 0, nrf = 0, i, s;
	pfwp_top pfwp_top_i (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .cfg_load_i, .cfg_word_i, .cfg_upset_i, .req_valid_i,
		.req_ext_i, .req_write_i, .req_addr_i, .grant_o, .nonvolatile_memory_interlock_o,
		.refuse_o, .dev_reset_o, .parity_err_o);
	pfwp_nvm_model pfwp_nvm_model_i (.mclk_i, .rst_i, .wr_i(req_valid_i && req_write_i),
		.unlock_i(nonvolatile_memory_interlock_o), .hits_o(hits));
	always #2.5 mclk_i = ~mclk_i;
	// hang guard: the run needs well under 5000 cycles
	always @(posedge mclk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			close_out;
		end
	end
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("Error %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d fails %0d", checks, fails);
			if (fails == 0 && checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// ======================================================================
	// apb master: setup, then access held until pready is seen at an edge
	task apb(input w, input [11:0] ad, input [31:0] d);
		begin
			@(posedge mclk_i);
			psel_i <= 1;
			pwrite_i <= w;
			paddr_i <= ad;
			pwdata_i <= d;
			@(posedge mclk_i);
			penable_i <= 1;
			@(posedge mclk_i);
			while (pready_o !== 1'b1) @(posedge mclk_i);
			rd = prdata_o;
			err = pslverr_o;
			psel_i <= 0;
			penable_i <= 0;
		end
	endtask
	function exp_ok(input e, input w, input [16:0] ad);
		reg seg;
		begin
			seg = !cfg[8] && (cfg[6] ? ad >= {cfg[5:0], 9'h000} : ad <= {cfg[5:0], 9'h1FF});
			exp_ok = !(e && !cfg[10]) && !(w && (!cfg[9] || seg || (!cfg[7] && ad >= 17'h0AA00)));
		end
	endfunction
	// one request cycle; the decision shows one edge later
	task req(input e, input w, input [16:0] ad);
		reg ok;
		begin
			ok = exp_ok(e, w, ad);
			@(posedge mclk_i);
			req_valid_i <= 1;
			req_ext_i <= e;
			req_write_i <= w;
			req_addr_i <= ad;
			@(posedge mclk_i);
			req_valid_i <= 0;
			#1;
			chk("decision", {grant_o, refuse_o, nonvolatile_memory_interlock_o}, {ok, !ok, ok && w});
			nwr = nwr + (ok && w);
			nrf = (nrf == 255) ? 255 : nrf + !ok;
			if (!ok) lr = ad;
		end
	endtask
	initial begin
		s = $urandom(62);
		repeat (16) @(posedge mclk_i);
		rst_i <= 0;
		apb(0, 12'h000, 0);
		chk("cfg reset", rd, 32'h7FF);
		for (i = 0; i < 300; i = i + 1) begin
			cfg = $urandom;
			@(posedge mclk_i);
			cfg_load_i <= 1;
			cfg_word_i <= {5'h00, cfg};
			@(posedge mclk_i);
			cfg_load_i <= 0;
			// page edges, the last page border and the configuration words
			a = {cfg[5:0], 9'h000} + (($urandom % 2) ? 17'h001FF : 17'h1FFFF) + $urandom % 2;
			if (i % 4 == 1) a = $urandom % 17'h0AC00;
			if (i % 4 == 2) a = 17'h0A9FF + $urandom % 2;
			if (i % 4 == 3) a = 17'h0ABFE + $urandom % 2;
			req($urandom, $urandom, a);
		end
		apb(0, 12'h000, 0);
		chk("cfg loaded", rd, {21'h0, cfg});
		chk("commits", hits, nwr);
		apb(0, 12'h008, 0);
		chk("refusals", rd[7:0], nrf);
		apb(0, 12'h00C, 0);
		chk("last refused", rd, {15'h0000, lr});
		apb(1, 12'h008, 0);
		apb(0, 12'h008, 0);
		chk("cleared", rd[7:0], 0);
		apb(0, 12'h010, 0);
		chk("unmapped", err, 1);
		$display("decision and register tests done");
		@(posedge mclk_i);
		cfg_upset_i <= $urandom | 1;
		@(posedge mclk_i);
		cfg_upset_i <= 0;
		// flip at the next edge, flag one edge later, outputs the edge after that
		repeat (2) @(posedge mclk_i);
		#1;
		chk("parity", {parity_err_o, dev_reset_o}, 2'h3);
		repeat (10) @(posedge mclk_i);
		#1;
		chk("reset end", {parity_err_o, dev_reset_o}, 2'h2);
		apb(0, 12'h004, 0);
		chk("status", rd[1:0], 2'h3);
		$display("parity test done");
		close_out;
	end
endmodule
bind pfwp_top pfwp_sva pfwp_sva_i (.mclk_i, .rst_i, .psel_i, .penable_i, .pready_o, .cfg_load_i,
	.cfg_word_i, .cfg_upset_i, .req_valid_i, .req_ext_i, .req_write_i, .req_addr_i, .grant_o,
	.nonvolatile_memory_interlock_o, .refuse_o, .dev_reset_o, .parity_err_o);
